// >>> verilog/gps_map.vh
`ifndef GPS_MAP_VH
`define GPS_MAP_VH
// Notes on behaviour
// - A write that tries to change a pin bit held by the lock mask sets the violation flag.
// - The violation flag is bit 0 of the access status word and stays set until written 0.
// - Each port has a read-only presence word, one for a pin that exists, zero otherwise.
// - A presence bit tells whether that pin's enable bit exists; absent pins store nothing.
// - The revision word holds a 12-bit version in bits 11..0 and a variant in bits 19..16.
// - The variant field is reserved and drives no behaviour.
// - The block has two ports and each pin selects one of eight peripheral functions.
// - Each pin's pull-up follows the pull-up mask, or the driving peripheral's request.
// - Every port register resets to zero unless another reset note says otherwise.
// - Port 0 resets enable 004DFF5F, mux bit 0 00320020 and mux bit 1 00020080.
// - Port 0 resets mux bit 2 00100800, pull-up 00000001 and filter 007FFFFF.
// - Port 1 resets enable 00FFFFCF and both mux bit 0 and mux bit 1 to 00000030.
// - Port 1 resets its filter enable to 00FFFFFF.
// - The presence word reads 007FFFFF on port 0 and 00FFFFFF on port 1.
// - A pin whose lock bit is one keeps its bit in every lockable port register.

// address layout
`define GPS_PORT_BIT 9
`define GPS_GLOB_BIT 10
`define GPS_GRP_MASK 9'h1F0
`define GPS_OFF_GEN 9'h000
`define GPS_OFF_MUX0 9'h010
`define GPS_OFF_MUX1 9'h020
`define GPS_OFF_MUX2 9'h030
`define GPS_OFF_PULL 9'h070
`define GPS_OFF_FILT 9'h0C0
`define GPS_OFF_LOCK 9'h1A0
`define GPS_OFF_UNLOCK 9'h1E0
`define GPS_OFF_ACC 9'h1E4
`define GPS_OFF_PRES 9'h1F8
`define GPS_OFF_REV 9'h1FC
`define GPS_OFF_IRQ_STAT 9'h000
`define GPS_OFF_IRQ_EN 9'h004
`define GPS_OFF_IRQ_CLR 9'h008

// sub-register access modes, address bits 3..2
`define GPS_MODE_WR 2'd0
`define GPS_MODE_SET 2'd1
`define GPS_MODE_CLR 2'd2
`define GPS_MODE_TGL 2'd3

// unlock word fields
`define GPS_KEY 8'hAA
`define GPS_KEY_LSB 24
`define GPS_UNL_OFF_W 10

// field positions
`define GPS_AVF_BIT 0
`define GPS_VAR_LSB 16

// revision word contents, values arbitrary
`define GPS_REV_VER 12'h101
`define GPS_REV_VAR 4'h0

// reset values
`define GPS_RST_ZERO 32'h0000_0000
`define GPS_RST_P0_GEN 32'h004D_FF5F
`define GPS_RST_P0_MUX0 32'h0032_0020
`define GPS_RST_P0_MUX1 32'h0002_0080
`define GPS_RST_P0_MUX2 32'h0010_0800
`define GPS_RST_P0_PULL 32'h0000_0001
`define GPS_RST_P0_FILT 32'h007F_FFFF
`define GPS_RST_P1_GEN 32'h00FF_FFCF
`define GPS_RST_P1_MUX0 32'h0000_0030
`define GPS_RST_P1_MUX1 32'h0000_0030
`define GPS_RST_P1_FILT 32'h00FF_FFFF
`define GPS_PRES_P0 32'h007F_FFFF
`define GPS_PRES_P1 32'h00FF_FFFF
`endif

// >>> verilog/gps_lock_reg.v
`timescale 1ns/10ps
`include "gps_map.vh"
module gps_lock_reg #(
    parameter [31:0] RST = 32'h0000_0000,
    parameter [31:0] IMPL = 32'hFFFF_FFFF
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // write request
    input wire wr,
    input wire [1:0] mode,
    input wire [31:0] wdata,
    input wire [31:0] lock_mask,
    // state
    output reg [31:0] value,
    output wire violation
);
    reg [31:0] raw;
    wire [31:0] keep;
    wire [31:0] next_value;

    // requested value for each access mode
    always @*
    begin
        case (mode)
            `GPS_MODE_SET: raw = value | wdata;
            `GPS_MODE_CLR: raw = value & ~wdata;
            `GPS_MODE_TGL: raw = value ^ wdata;
            default: raw = wdata;
        endcase
    end

    // locked pins and absent pins both hold their bit
    assign keep = lock_mask | ~IMPL;
    assign next_value = (raw & ~keep) | (value & keep);
    // only a real change to a locked pin counts as an attempt
    assign violation = wr & (|((raw ^ value) & lock_mask & IMPL));

    // the register itself; a blocked bit simply keeps its value
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            value <= RST;
        else if (wr)
            value <= next_value;
    end
endmodule

// >>> verilog/gps_top.v
`timescale 1ns/10ps
`include "gps_map.vh"
module gps_top (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb request
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // apb answer
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // peripheral pull-up requests, port 1 in the upper word
    input wire [63:0] periph_pullup_req,
    // pin controls, port 1 in the upper word
    output wire [63:0] gpio_enable_mask,
    output wire [63:0] periph_mux_select_bit0,
    output wire [63:0] periph_mux_select_bit1,
    output wire [63:0] periph_mux_select_bit2,
    output wire [63:0] pullup_enable_mask,
    output wire [63:0] glitch_filter_enable_mask,
    output reg [63:0] pin_lock,
    output reg [63:0] pin_pullup,
    // interrupt
    output reg irq
);
    // per-port reset values, six lockable registers per port
    localparam [383:0] RST_ALL = {
        `GPS_RST_P1_FILT,
        `GPS_RST_ZERO,
        `GPS_RST_ZERO,
        `GPS_RST_P1_MUX1,
        `GPS_RST_P1_MUX0,
        `GPS_RST_P1_GEN,
        `GPS_RST_P0_FILT,
        `GPS_RST_P0_PULL,
        `GPS_RST_P0_MUX2,
        `GPS_RST_P0_MUX1,
        `GPS_RST_P0_MUX0,
        `GPS_RST_P0_GEN
    };
    localparam [63:0] PRES_ALL = {`GPS_PRES_P1, `GPS_PRES_P0};
    localparam NREG = 6;

    wire access_ph;
    wire commit;
    wire wr_commit;
    wire port_sel;
    wire glob;
    wire [8:0] off;
    wire [8:0] grp;
    wire [1:0] mode;
    wire [383:0] reg_val;
    wire [11:0] viol;
    wire [1:0] port_viol;
    wire [31:0] rev_word;
    wire [3:0] rsel;

    reg [2:0] grp_idx;
    reg grp_hit;
    reg lock_hit;
    reg unlock_hit;
    reg acc_hit;
    reg pres_hit;
    reg rev_hit;
    reg ist_hit;
    reg ien_hit;
    reg icl_hit;
    reg addr_ok;
    reg [31:0] next_rdata;

    reg unl_armed;
    reg [9:0] unl_off;
    reg [1:0] acc_flag;
    reg [1:0] next_acc_flag;
    reg [1:0] irq_status;
    reg [1:0] irq_enable;
    reg [1:0] next_irq_status;
    reg [1:0] next_irq_enable;
    reg [63:0] next_lock;

    integer i;

    // apb phases; every access takes exactly one wait state
    assign access_ph = psel & penable;
    assign commit = access_ph & pready;
    assign wr_commit = commit & pwrite & addr_ok;

    // address fields
    assign port_sel = paddr[`GPS_PORT_BIT];
    assign glob = paddr[`GPS_GLOB_BIT];
    assign off = paddr[8:0];
    assign grp = off & `GPS_GRP_MASK;
    assign mode = off[3:2];

    // revision word; the variant field only ever reads back
    assign rev_word = {12'h000, `GPS_REV_VAR, 4'h0, `GPS_REV_VER};

    // decode; the top address bit is never mapped
    always @*
    begin
        grp_idx = 3'd0;
        grp_hit = 1'b0;
        lock_hit = 1'b0;
        unlock_hit = 1'b0;
        acc_hit = 1'b0;
        pres_hit = 1'b0;
        rev_hit = 1'b0;
        ist_hit = 1'b0;
        ien_hit = 1'b0;
        icl_hit = 1'b0;
        if (paddr[11])
            grp_hit = 1'b0;
        else if (glob)
        begin
            if (port_sel)
                grp_hit = 1'b0;
            else if (off == `GPS_OFF_IRQ_STAT)
                ist_hit = 1'b1;
            else if (off == `GPS_OFF_IRQ_EN)
                ien_hit = 1'b1;
            else if (off == `GPS_OFF_IRQ_CLR)
                icl_hit = 1'b1;
        end
        else if (grp == `GPS_OFF_GEN)
        begin
            grp_hit = 1'b1;
            grp_idx = 3'd0;
        end
        else if (grp == `GPS_OFF_MUX0)
        begin
            grp_hit = 1'b1;
            grp_idx = 3'd1;
        end
        else if (grp == `GPS_OFF_MUX1)
        begin
            grp_hit = 1'b1;
            grp_idx = 3'd2;
        end
        else if (grp == `GPS_OFF_MUX2)
        begin
            grp_hit = 1'b1;
            grp_idx = 3'd3;
        end
        else if (grp == `GPS_OFF_PULL)
        begin
            grp_hit = 1'b1;
            grp_idx = 3'd4;
        end
        else if (grp == `GPS_OFF_FILT)
        begin
            grp_hit = 1'b1;
            grp_idx = 3'd5;
        end
        else if (grp == `GPS_OFF_LOCK)
            lock_hit = 1'b1;
        else if (off[8:2] == `GPS_OFF_UNLOCK >> 2)
            unlock_hit = 1'b1;
        else if (off[8:2] == `GPS_OFF_ACC >> 2)
            acc_hit = 1'b1;
        else if (off[8:2] == `GPS_OFF_PRES >> 2)
            pres_hit = 1'b1;
        else if (off[8:2] == `GPS_OFF_REV >> 2)
            rev_hit = 1'b1;
        addr_ok = grp_hit | lock_hit | unlock_hit | acc_hit | pres_hit
            | rev_hit | ist_hit | ien_hit | icl_hit;
    end

    // lockable register pick for reads
    assign rsel = (port_sel ? 4'd6 : 4'd0) + {1'b0, grp_idx};

    // six lockable registers in each of the two ports
    genvar p;
    genvar r;
    generate
        for (p = 0; p < 2; p = p + 1)
        begin : g_port
            for (r = 0; r < NREG; r = r + 1)
            begin : g_reg
                gps_lock_reg #(
                    .RST(RST_ALL[(p * NREG + r) * 32 +: 32]),
                    .IMPL(PRES_ALL[p * 32 +: 32])
                ) u_reg (
                    .pclk(pclk),
                    .presetn(presetn),
                    .wr(wr_commit & grp_hit & (port_sel == p) & (grp_idx == r)),
                    .mode(mode),
                    .wdata(pwdata),
                    .lock_mask(pin_lock[p * 32 +: 32]),
                    .value(reg_val[(p * NREG + r) * 32 +: 32]),
                    .violation(viol[p * NREG + r])
                );
            end
            assign port_viol[p] = |viol[p * NREG +: NREG];
            assign gpio_enable_mask[p * 32 +: 32] = reg_val[(p * NREG) * 32 +: 32];
            assign periph_mux_select_bit0[p * 32 +: 32] =
                reg_val[(p * NREG + 1) * 32 +: 32];
            assign periph_mux_select_bit1[p * 32 +: 32] =
                reg_val[(p * NREG + 2) * 32 +: 32];
            assign periph_mux_select_bit2[p * 32 +: 32] =
                reg_val[(p * NREG + 3) * 32 +: 32];
            assign pullup_enable_mask[p * 32 +: 32] = reg_val[(p * NREG + 4) * 32 +: 32];
            assign glitch_filter_enable_mask[p * 32 +: 32] =
                reg_val[(p * NREG + 5) * 32 +: 32];
        end
    endgenerate

    // lock mask: set mode is always open, the other modes need a fresh unlock
    always @*
    begin
        next_lock = pin_lock;
        if (wr_commit & lock_hit)
        begin
            if (mode == `GPS_MODE_SET)
            begin
                if (port_sel)
                    next_lock[63:32] = pin_lock[63:32] | pwdata;
                else
                    next_lock[31:0] = pin_lock[31:0] | pwdata;
            end
            else if (unl_armed & (unl_off == paddr[9:0]))
            begin
                if (port_sel)
                    next_lock[63:32] = (mode == `GPS_MODE_CLR) ? pin_lock[63:32] & ~pwdata
                        : (mode == `GPS_MODE_TGL) ? pin_lock[63:32] ^ pwdata : pwdata;
                else
                    next_lock[31:0] = (mode == `GPS_MODE_CLR) ? pin_lock[31:0] & ~pwdata
                        : (mode == `GPS_MODE_TGL) ? pin_lock[31:0] ^ pwdata : pwdata;
            end
        end
        next_lock = next_lock & PRES_ALL;
    end

    // unlock window lasts for exactly the next mapped write, whatever register it targets
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            unl_armed <= 1'b0;
            unl_off <= 10'h000;
            pin_lock <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            pin_lock <= next_lock;
            if (wr_commit)
            begin
                unl_armed <= unlock_hit & (pwdata[31:`GPS_KEY_LSB] == `GPS_KEY);
                unl_off <= pwdata[`GPS_UNL_OFF_W - 1:0];
            end
        end
    end

    // access violation flags; a new violation beats a clear in the same cycle
    always @*
    begin
        next_acc_flag = acc_flag;
        if (wr_commit & acc_hit & ~pwdata[`GPS_AVF_BIT])
            next_acc_flag[port_sel] = 1'b0;
        next_acc_flag = next_acc_flag | port_viol;
    end

    // interrupt status, enable and write-one-to-clear
    always @*
    begin
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        if (wr_commit & icl_hit)
            next_irq_status = irq_status & ~pwdata[1:0];
        if (wr_commit & ien_hit)
            next_irq_enable = pwdata[1:0];
        next_irq_status = next_irq_status | port_viol;
    end

    // flag and interrupt registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_flag <= 2'b00;
            irq_status <= 2'b00;
            irq_enable <= 2'b00;
            irq <= 1'b0;
        end
        else
        begin
            acc_flag <= next_acc_flag;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            irq <= |(next_irq_status & next_irq_enable);
        end
    end

    // pull-up: software mask while gpio owns the pin, else the peripheral
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin_pullup <= 64'h0000_0000_0000_0000;
        else
        begin
            for (i = 0; i < 64; i = i + 1)
                pin_pullup[i] <= PRES_ALL[i] & (gpio_enable_mask[i] ?
                    pullup_enable_mask[i] : periph_pullup_req[i]);
        end
    end

    // read data; write-only words and unmapped words read zero
    always @*
    begin
        next_rdata = 32'h0000_0000;
        if (grp_hit)
            next_rdata = reg_val[rsel * 32 +: 32];
        else if (lock_hit)
            next_rdata = port_sel ? pin_lock[63:32] : pin_lock[31:0];
        else if (acc_hit)
            next_rdata = {31'h0000_0000, acc_flag[port_sel]};
        else if (pres_hit)
            next_rdata = port_sel ? PRES_ALL[63:32] : PRES_ALL[31:0];
        else if (rev_hit)
            next_rdata = rev_word;
        else if (ist_hit)
            next_rdata = {30'h0000_0000, irq_status};
        else if (ien_hit)
            next_rdata = {30'h0000_0000, irq_enable};
    end

    // apb answer: pready rises one cycle into the access phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (access_ph & ~pready)
        begin
            pready <= 1'b1;
            pslverr <= ~addr_ok;
            prdata <= pwrite ? 32'h0000_0000 : next_rdata;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end
endmodule

// >>> testbench/gps_top_assertions.sv
`timescale 1ns/10ps
`include "gps_map.vh"
module gps_chk (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pins
    input wire [63:0] periph_pullup_req,
    input wire [63:0] gpio_enable_mask,
    input wire [63:0] periph_mux_select_bit0,
    input wire [63:0] periph_mux_select_bit1,
    input wire [63:0] periph_mux_select_bit2,
    input wire [63:0] pullup_enable_mask,
    input wire [63:0] glitch_filter_enable_mask,
    input wire [63:0] pin_lock,
    input wire [63:0] pin_pullup,
    input wire irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed transfer and the pins that exist
    wire acc = psel && penable && pready;
    wire rdg = acc && !pwrite && paddr[11:10] == 2'b00;
    wire [63:0] pres = {`GPS_PRES_P1, `GPS_PRES_P0};
    wire [63:0] pull_src = (gpio_enable_mask & pullup_enable_mask)
        | (~gpio_enable_mask & periph_pullup_req);

    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("no answer after access phase");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_err; pslverr |-> pready && prdata == 32'h0000_0000; endproperty
    a_err: assert property (p_err) else $error("error answer malformed");
    property p_pres;
        rdg && paddr[8:0] == `GPS_OFF_PRES |->
            prdata == (paddr[9] ? `GPS_PRES_P1 : `GPS_PRES_P0);
    endproperty
    a_pres: assert property (p_pres) else $error("presence word wrong");
    property p_rev;
        rdg && paddr[8:0] == `GPS_OFF_REV |->
            prdata == {12'h000, `GPS_REV_VAR, 4'h0, `GPS_REV_VER};
    endproperty
    a_rev: assert property (p_rev) else $error("revision word wrong");
    property p_lock;
        (((gpio_enable_mask ^ $past(gpio_enable_mask))
            | (pullup_enable_mask ^ $past(pullup_enable_mask))) & $past(pin_lock)) == 64'h0;
    endproperty
    a_lock: assert property (p_lock) else $error("locked bit changed");
    property p_absent; ((gpio_enable_mask | pin_lock) & ~pres) == 64'h0; endproperty
    a_absent: assert property (p_absent) else $error("absent pin bit set");
    property p_pull; $past(presetn) |-> pin_pullup == $past(pull_src & pres); endproperty
    a_pull: assert property (p_pull) else $error("pull-up wrong");
    property p_irq_up; $rose(irq) |-> $past(acc && pwrite) || $past(acc && pwrite, 2); endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq rose without a write");
    property p_irq_dn; $fell(irq) |-> $past(acc && pwrite) || $past(acc && pwrite, 2); endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("irq fell without a write");
    c_err: cover property (pslverr);
    c_irq: cover property ($rose(irq));
    c_acc: cover property (acc && pwrite && paddr[8:0] == `GPS_OFF_ACC);
endmodule
bind gps_top gps_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_pullup_req(periph_pullup_req),
    .gpio_enable_mask(gpio_enable_mask), .periph_mux_select_bit0(periph_mux_select_bit0),
    .periph_mux_select_bit1(periph_mux_select_bit1),
    .periph_mux_select_bit2(periph_mux_select_bit2), .pullup_enable_mask(pullup_enable_mask),
    .glitch_filter_enable_mask(glitch_filter_enable_mask), .pin_lock(pin_lock),
    .pin_pullup(pin_pullup), .irq(irq));

// >>> testbench/tb_gps_top.sv
`timescale 1ns/10ps
`include "gps_map.vh"
module tb_gps_top;
    // stimulus
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [63:0] req = 64'h0;
    // design answers
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [63:0] en, mx0, mx1, mx2, pu, gf, lk, pp;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int f;
    logic [32:0] expq[$];
    logic [32:0] e;
    logic [31:0] lkv, v;
    logic [63:0] pexp;

    always #4 pclk = ~pclk;

    gps_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_pullup_req(req), .gpio_enable_mask(en),
        .periph_mux_select_bit0(mx0), .periph_mux_select_bit1(mx1),
        .periph_mux_select_bit2(mx2), .pullup_enable_mask(pu),
        .glitch_filter_enable_mask(gf), .pin_lock(lk), .pin_pullup(pp), .irq(irq));

    task automatic results;
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; calls in a row run back to back with no idle cycle
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic err);
        if (psel !== 1'b1)
            @(posedge pclk);
        expq.push_back({err, d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk iff pready === 1'b1);
    endtask

    // bus idle, then park mid-cycle so registered outputs are settled
    task automatic settle;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
    endtask

    // watchdog and answer checker; read data only matters on reads
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            results();
        end
        else if (psel && penable && pready === 1'b1 && expq.size() > 0)
        begin
            e = expq.pop_front();
            if (!pwrite)
                chk("prdata", prdata, e[31:0]);
            chk("pslverr", pslverr, e[32]);
        end
    end

    initial
    begin
        v = $urandom(89299);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        req <= {$urandom, $urandom};
        chk("en", en, {`GPS_RST_P1_GEN, `GPS_RST_P0_GEN});
        chk("mx0", mx0, {`GPS_RST_P1_MUX0, `GPS_RST_P0_MUX0});
        chk("mx1", mx1, {`GPS_RST_P1_MUX1, `GPS_RST_P0_MUX1});
        chk("mx2", mx2, {`GPS_RST_ZERO, `GPS_RST_P0_MUX2});
        chk("pu", pu, {`GPS_RST_ZERO, `GPS_RST_P0_PULL});
        chk("gf", gf, {`GPS_RST_P1_FILT, `GPS_RST_P0_FILT});
        // pull-up from reset masks and the random peripheral requests
        settle;
        pexp[63:32] = ~`GPS_RST_P1_GEN & req[63:32];
        pexp[31:0] = (`GPS_RST_P0_GEN & `GPS_RST_P0_PULL) | (~`GPS_RST_P0_GEN & req[31:0]);
        chk("pp", pp, pexp & {`GPS_PRES_P1, `GPS_PRES_P0});
        xfer(0, 12'h1E4, 32'h0, 0);
        xfer(0, 12'h3F8, `GPS_PRES_P1, 0);
        xfer(1, 12'h3F8, 32'h0, 0);
        xfer(0, 12'h3F8, `GPS_PRES_P1, 0);
        xfer(0, 12'h1FC, {12'h000, `GPS_REV_VAR, 4'h0, `GPS_REV_VER}, 0);
        // absent pins keep no enable bit
        xfer(1, 12'h000, 32'hFFFF_FFFF, 0);
        xfer(1, 12'h200, 32'hFFFF_FFFF, 0);
        xfer(0, 12'h000, `GPS_PRES_P0, 0);
        xfer(0, 12'h200, `GPS_PRES_P1, 0);
        xfer(1, 12'h20C, 32'h0000_000F, 0);
        xfer(1, 12'h208, 32'h0000_0F00, 0);
        xfer(0, 12'h200, 32'h00FF_F0F0, 0);
        xfer(0, 12'h800, 32'h0, 1);
        xfer(1, 12'h100, 32'h0000_0005, 1);
        // every peripheral function on one pin of port 1
        for (f = 0; f < 8; f++)
        begin
            xfer(1, 12'h210, {31'h0, f[0]}, 0);
            req <= {$urandom, $urandom};
            xfer(1, 12'h220, {31'h0, f[1]}, 0);
            xfer(1, 12'h230, {31'h0, f[2]}, 0);
            settle;
            chk("mux", {mx2[32], mx1[32], mx0[32]}, f[2:0]);
        end
        // locked write: flag, sticky clear, irq raised, cleared and masked
        lkv = ($urandom | 32'h1) & `GPS_PRES_P0;
        v = $urandom & 32'hFFFF_FFFE;
        xfer(1, 12'h1A4, lkv, 0);
        xfer(0, 12'h1A0, lkv, 0);
        xfer(1, 12'h404, 32'h1, 0);
        xfer(1, 12'h000, v, 0);
        xfer(0, 12'h000, (`GPS_PRES_P0 & lkv) | (v & ~lkv & `GPS_PRES_P0), 0);
        xfer(0, 12'h1E4, 32'h1, 0);
        settle;
        chk("irq", irq, 1'b1);
        chk("lk", lk, {32'h0000_0000, lkv});
        xfer(1, 12'h1E4, 32'h1, 0);
        xfer(0, 12'h1E4, 32'h1, 0);
        xfer(1, 12'h408, 32'h1, 0);
        settle;
        chk("irq", irq, 1'b0);
        xfer(1, 12'h1E4, 32'h0, 0);
        xfer(0, 12'h1E4, 32'h0, 0);
        xfer(1, 12'h404, 32'h0, 0);
        xfer(1, 12'h000, v, 0);
        xfer(0, 12'h400, 32'h1, 0);
        settle;
        chk("irq", irq, 1'b0);
        xfer(1, 12'h404, 32'h1, 0);
        settle;
        chk("irq", irq, 1'b1);
        // protected lock clear: ignored until a keyed unlock names it
        xfer(1, 12'h1A8, 32'hFFFF_FFFF, 0);
        xfer(0, 12'h1A0, lkv, 0);
        xfer(0, 12'h1E0, 32'h0, 0);
        xfer(1, 12'h1E0, {`GPS_KEY, 14'h0000, 10'h1A8}, 0);
        xfer(1, 12'h1A8, 32'hFFFF_FFFF, 0);
        xfer(0, 12'h1A0, 32'h0, 0);
        settle;
        chk("lk", lk, 64'h0000_0000_0000_0000);
        results();
    end
endmodule
